// *** core/irq_status_bank.sv ***
// Chosen here: register access over APB.
`include "irq_status_map.svh"

module irq_status_bank
  import irq_status_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          pclk,    // core clock, 100 MHz
  input  wire logic          presetn, // async reset, active low
  input  wire logic          ce,      // clock enable, freezes state
  input  wire logic          psel,    // apb select
  input  wire logic          penable, // apb access phase
  input  wire logic          pwrite,  // apb direction, 1 = write
  input  wire logic [AW-1:0] paddr,   // apb byte address
  input  wire logic [31:0]   pwdata,  // apb write data
  output logic               pready,  // apb ready
  output logic [31:0]        prdata,  // apb read data, registered
  output logic               pslverr, // apb error, unmapped address
  input  wire ch_cond_t      ch0,     // channel 0 conditions
  input  wire ch_cond_t      ch1,     // channel 1 conditions
  output logic               irq_n,   // latched status, active low
  output logic               irq      // masked event summary
);

  // ---- request bundle ----
  apb_req_t req;

  assign req.sel    = psel;
  assign req.enable = penable;
  assign req.write  = pwrite;
  assign req.addr   = 12'(paddr);
  assign req.wdata  = pwdata;

  // ---- address decode ----
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] idx);
    hit = (a == 12'(idx << 2));
  endfunction : hit

  wire logic hit_st1  = hit(req.addr, `IDX_STATUS_ONE);
  wire logic hit_st2  = hit(req.addr, `IDX_STATUS_TWO);
  wire logic hit_st3  = hit(req.addr, `IDX_STATUS_THREE);
  wire logic hit_md1  = hit(req.addr, `IDX_MODE_ONE);
  wire logic hit_md2  = hit(req.addr, `IDX_MODE_TWO);
  wire logic hit_md3  = hit(req.addr, `IDX_MODE_THREE);
  wire logic hit_evs  = hit(req.addr, `IDX_EVT_STATUS);
  wire logic hit_evm  = hit(req.addr, `IDX_EVT_MASK);

  wire logic mapped = hit_st1 | hit_st2 | hit_st3 |
                      hit_md1 | hit_md2 | hit_md3 |
                      hit_evs | hit_evm;

  // ---- transfer phases ----
  logic rd_valid_reg;
  logic rd_valid_next;

  wire logic setup    = req.sel & ~req.enable;
  wire logic access   = req.sel & req.enable;
  // answer only once read data has been captured and the clock runs
  wire logic done     = access & rd_valid_reg & ce;
  wire logic wr_done  = done & req.write & mapped;
  wire logic rd_done  = done & ~req.write & mapped;

  assign pready  = access & rd_valid_reg & ce;
  assign pslverr = pready & ~mapped;

  // capture flag: set on first selected cycle of a transfer, cleared at end
  assign rd_valid_next = done ? 1'b0 :
                         (req.sel ? 1'b1 : rd_valid_reg);

  // ---- software registers ----
  logic [7:0] mode1_reg;
  logic [7:0] mode2_reg;
  logic [7:0] mode3_reg;
  logic [2:0] evt_mask_reg;
  logic [2:0] evt_reg;
  logic [2:0] evt_next;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;

  wire logic [7:0] wbyte = req.wdata[7:0];

  // ---- condition vectors in register layout ----
  logic [7:0] cond1;
  logic [7:0] cond2;
  logic [7:0] cond3;

  // status one carries both pattern checkers
  assign cond1 = {5'h00, ch1.pattern_fail, 1'b0, ch0.pattern_fail};

  // status two: channel 0
  assign cond2[`BIT_POWER_OVER]   = ch0.power_over;
  assign cond2[6]                 = 1'b0;
  assign cond2[`BIT_BLANK_DONE]   = ch0.blank_complete;
  assign cond2[4]                 = 1'b0;
  assign cond2[`BIT_ALIGN_LOCK]   = ch0.align_locked;
  assign cond2[`BIT_ALIGN_ROTATE] = ch0.align_rotated;
  assign cond2[`BIT_PHASE_WINDOW] = ch0.phase_out_of_window;
  assign cond2[`BIT_ALIGN_TRIP]   = ch0.align_tripped;

  // status three: channel 1, same layout
  assign cond3[`BIT_POWER_OVER]   = ch1.power_over;
  assign cond3[6]                 = 1'b0;
  assign cond3[`BIT_BLANK_DONE]   = ch1.blank_complete;
  assign cond3[4]                 = 1'b0;
  assign cond3[`BIT_ALIGN_LOCK]   = ch1.align_locked;
  assign cond3[`BIT_ALIGN_ROTATE] = ch1.align_rotated;
  assign cond3[`BIT_PHASE_WINDOW] = ch1.phase_out_of_window;
  assign cond3[`BIT_ALIGN_TRIP]   = ch1.align_tripped;

  // ---- write-one-to-clear strobes ----
  wire logic [7:0] clr1 = (wr_done & hit_st1) ? wbyte : 8'h00;
  wire logic [7:0] clr2 = (wr_done & hit_st2) ? wbyte : 8'h00;
  wire logic [7:0] clr3 = (wr_done & hit_st3) ? wbyte : 8'h00;

  // ---- status lanes ----
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] st3;
  logic [7:0] lat1;
  logic [7:0] lat2;
  logic [7:0] lat3;
  logic [2:0] new_evt;

  status_lane #(
    .W    (8),
    .IMPL (`IMPL_ONE)
  ) u_lane_one (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .cond      (cond1),
    .latch_sel (mode1_reg),
    .clr       (clr1),
    .status    (st1),
    .latched   (lat1),
    .new_event (new_evt[0])
  );

  status_lane #(
    .W    (8),
    .IMPL (`IMPL_CHAN)
  ) u_lane_two (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .cond      (cond2),
    .latch_sel (mode2_reg),
    .clr       (clr2),
    .status    (st2),
    .latched   (lat2),
    .new_event (new_evt[1])
  );

  status_lane #(
    .W    (8),
    .IMPL (`IMPL_CHAN)
  ) u_lane_three (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .cond      (cond3),
    .latch_sel (mode3_reg),
    .clr       (clr3),
    .status    (st3),
    .latched   (lat3),
    .new_event (new_evt[2])
  );

  // ---- interrupt outputs ----
  // low for as long as any latched bit remains; live bits never pull it
  assign irq_n = ~(|lat1 | |lat2 | |lat3);
  // summary line: one sticky bit per status register, masked
  assign irq   = |(evt_reg & evt_mask_reg);

  // sticky events; a new event in the read cycle survives the clear
  wire logic evt_rd_clr = rd_done & hit_evs;

  assign evt_next = (evt_rd_clr ? 3'h0 : evt_reg) | new_evt;

  // ---- read multiplexer ----
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_st1: rd_mux[7:0] = st1;
      hit_st2: rd_mux[7:0] = st2;
      hit_st3: rd_mux[7:0] = st3;
      hit_md1: rd_mux[7:0] = mode1_reg;
      hit_md2: rd_mux[7:0] = mode2_reg;
      hit_md3: rd_mux[7:0] = mode3_reg;
      hit_evs: rd_mux[2:0] = evt_reg;
      hit_evm: rd_mux[2:0] = evt_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign prdata = prdata_reg;

  // ---- transfer state and read capture ----
  // data are captured one cycle ahead so prdata can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_reg <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
    end else if (ce) begin
      rd_valid_reg <= rd_valid_next;
      if (req.sel && !rd_valid_reg) begin
        prdata_reg <= req.write ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ---- mode select registers ----
  // only implemented bits can be made to latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode1_reg <= `RST_MODE;
      mode2_reg <= `RST_MODE;
      mode3_reg <= `RST_MODE;
    end else if (ce && wr_done) begin
      if (hit_md1) begin
        mode1_reg <= wbyte & `IMPL_ONE;
      end
      if (hit_md2) begin
        mode2_reg <= wbyte & `IMPL_CHAN;
      end
      if (hit_md3) begin
        mode3_reg <= wbyte & `IMPL_CHAN;
      end
    end
  end

  // ---- event summary and mask ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg      <= `RST_EVT;
      evt_mask_reg <= `RST_EVT;
    end else if (ce) begin
      evt_reg <= evt_next;
      if (wr_done && hit_evm) begin
        evt_mask_reg <= wbyte[2:0];
      end
    end
  end

  // setup is unused beyond documenting phase intent
  wire logic unused_ok = setup | (|req.wdata[31:8]);

endmodule : irq_status_bank

// *** shared/irq_status_map.svh ***
`ifndef IRQ_STATUS_MAP_SVH
`define IRQ_STATUS_MAP_SVH
// What this block does
// - mode select low: status bit shows its condition live, no interrupt.
// - mode select high: rising edge sets and holds bit, pulls irq_n low.
// - writing 1 clears a latched bit; bits written 0 stay unchanged.
// - status one: channel 1 pattern fail at bit 2, channel 0 at bit 0.
// - power over threshold: bit 7 of status two (ch0), three (ch1).
// - blanking complete: bit 5 of status two (ch0), three (ch1).
// - alignment locked: bit 3 of each channel's status register.
// - alignment rotated the clock phase: bit 2 of each channel register.
// - reference phase outside error window: bit 1 of each channel register.
// - channel 0 alignment tripped: bit 0 of status two.
// - channel 1 alignment tripped: bit 0 of status three, same behaviour.

// register indices; byte address is four times the index
`define IDX_STATUS_ONE    12'h024
`define IDX_STATUS_TWO    12'h025
`define IDX_STATUS_THREE  12'h026
`define IDX_MODE_ONE      12'h028
`define IDX_MODE_TWO      12'h029
`define IDX_MODE_THREE    12'h02a
`define IDX_EVT_STATUS    12'h02c
`define IDX_EVT_MASK      12'h02d

// field positions
`define BIT_CH1_PATTERN   2
`define BIT_CH0_PATTERN   0
`define BIT_POWER_OVER    7
`define BIT_BLANK_DONE    5
`define BIT_ALIGN_LOCK    3
`define BIT_ALIGN_ROTATE  2
`define BIT_PHASE_WINDOW  1
`define BIT_ALIGN_TRIP    0

// implemented bits; the rest read as zero
`define IMPL_ONE          8'h05
`define IMPL_CHAN         8'haf

// reset values
`define RST_STATUS        8'h00
`define RST_MODE          8'h00
`define RST_EVT           3'h0
`endif

// *** shared/irq_status_pkg.sv ***
package irq_status_pkg;

  // conditions of one converter channel
  typedef struct packed {
    logic pattern_fail;
    logic power_over;
    logic blank_complete;
    logic align_locked;
    logic align_rotated;
    logic phase_out_of_window;
    logic align_tripped;
  } ch_cond_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : irq_status_pkg

// *** core/status_lane.sv ***
module status_lane #(
  parameter int          W    = 8,
  parameter logic [W-1:0] IMPL = '1
) (
  input  wire logic         pclk,      // core clock
  input  wire logic         presetn,   // async reset, active low
  input  wire logic         ce,        // clock enable
  input  wire logic [W-1:0] cond,      // live conditions
  input  wire logic [W-1:0] latch_sel, // 1 = latch on rising edge
  input  wire logic [W-1:0] clr,       // write-one-to-clear strobes
  output logic      [W-1:0] status,    // value software reads
  output logic      [W-1:0] latched,   // bits currently latched
  output logic              new_event  // pulse: a bit newly latched
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] lat_reg;
  logic [W-1:0] lat_next;
  logic [W-1:0] rise;

  // edge of each condition, only on implemented bits
  assign rise = cond & ~prev_reg & IMPL;
  // set wins over a clear arriving in the same cycle
  assign lat_next = ((lat_reg & ~clr) | (rise & latch_sel)) & latch_sel;
  // live view when select is low, latched view when high
  assign status = ((latch_sel & lat_reg) | (~latch_sel & cond)) & IMPL;
  assign latched = lat_reg;
  assign new_event = |(rise & latch_sel & ~lat_reg);

  // condition history and latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
      lat_reg  <= '0;
    end else if (ce) begin
      prev_reg <= cond;
      lat_reg  <= lat_next;
    end
  end

endmodule : status_lane

// *** sim/irq_status_bank_chk.sv ***
module irq_status_bank_chk
  import irq_status_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic          pclk,    // clock
  input wire logic          presetn, // reset, low
  input wire logic          ce,      // enable
  input wire logic          psel,    // select
  input wire logic          penable, // access
  input wire logic          pwrite,  // direction
  input wire logic [AW-1:0] paddr,   // address
  input wire logic          pready,  // ready
  input wire logic [31:0]   prdata,  // read data
  input wire logic          pslverr, // error
  input wire ch_cond_t      ch0,     // ch0 conditions
  input wire ch_cond_t      ch1,     // ch1 conditions
  input wire logic          irq_n,   // latched, low
  input wire logic          irq      // event summary
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus handshake: zero wait once ce was high in setup
  AST_RDY_WAIT: assert property (psel && !penable && ce ##1
    psel && penable && ce |-> pready) else $error("ready late");
  AST_RDY_ACC: assert property (pready |-> psel && penable && ce)
    else $error("ready outside access");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  AST_HI_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("upper read bits set");
  // reserved status bits always read zero
  AST_ONE_RSV: assert property (
    pready && !pwrite && paddr == 12'h090 |-> (prdata[7:0] & 8'hfa) == 0)
    else $error("status one reserved bit set");
  AST_CHAN_RSV: assert property (
    pready && !pwrite && (paddr == 12'h094 || paddr == 12'h098)
    |-> (prdata[7:0] & 8'h50) == 0) else $error("channel reserved bit set");
  // irq_n may only release at a completed write
  AST_IRQN_HOLD: assert property (
    !irq_n && !(psel && penable && pready && pwrite) |=> !irq_n)
    else $error("irq_n released without write");
  // a latch needs a condition high at the setting edge
  AST_IRQN_CAUSE: assert property (
    $fell(irq_n) |-> ($past(ch0) | $past(ch1)) != 7'h0)
    else $error("irq_n fell without condition");

  COV_IRQN: cover property ($fell(irq_n));
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (irq);
endmodule : irq_status_bank_chk

bind irq_status_bank irq_status_bank_chk #(.AW(AW)) i_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .ch0(ch0), .ch1(ch1),
  .irq_n(irq_n), .irq(irq));

// *** sim/tb_dual_channel_irq_status.sv ***
`include "irq_status_map.svh"

module tb_dual_channel_irq_status
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] S1 = 12'(`IDX_STATUS_ONE * 4);
  localparam logic [11:0] S2 = 12'(`IDX_STATUS_TWO * 4);
  localparam logic [11:0] M1 = 12'(`IDX_MODE_ONE * 4);
  localparam logic [11:0] EV = 12'(`IDX_EVT_STATUS * 4);
  localparam logic [11:0] MK = 12'(`IDX_EVT_MASK * 4);
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic        pready, pslverr, irq_n, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ch_cond_t    ch0, ch1;
  int          miscompares, n_checks, i, c;
  int          pos [6] = '{0, 1, 2, 3, 5, 7};

  always #5 pclk = ~pclk;

  irq_status_bank i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch0(ch0),
    .ch1(ch1), .irq_n(irq_n), .irq(irq));

  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk32(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk1(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  // one transfer; result taken at the completing rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32($sformatf("read %h", a), e, rd);
  endtask : rdchk

  // settle past the edge before looking at the levels
  task automatic flags(input logic en, ei);
    @(negedge pclk);
    chk1("irq_n", en, irq_n);
    chk1("irq", ei, irq);
  endtask : flags

  task automatic pulse(input ch_cond_t a, b);
    @(posedge pclk);
    ch0 <= a;
    ch1 <= b;
    @(posedge pclk);
    ch0 <= '0;
    ch1 <= '0;
  endtask : pulse

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ch0, ch1, miscompares, n_checks} = '0;
    ce = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i++) rdchk(S1 + 12'(4 * i), 32'h0);
    flags(1'b1, 1'b0);
    $display("test reset done");
    // walk each condition alone through live mode
    for (c = 0; c < 2; c++) begin
      for (i = 0; i < 7; i++) begin
        @(posedge pclk);
        ch0 <= (c == 0) ? ch_cond_t'(7'(1 << i)) : '0;
        ch1 <= (c == 1) ? ch_cond_t'(7'(1 << i)) : '0;
        rdchk(S1, (i == 6) ? (c ? 32'h4 : 32'h1) : 32'h0);
        rdchk(S2 + 12'(4 * c), (i == 6) ? 0 : 32'h1 << pos[i]);
        flags(1'b1, 1'b0);
      end
    end
    pulse('0, '0);
    $display("test live done");
    apb(1'b1, M1, 32'h05);
    apb(1'b1, M1 + 12'h4, 32'haf);
    apb(1'b1, M1 + 12'h8, 32'haf);
    apb(1'b1, MK, 32'h7);
    pulse(7'h20, 7'h01);
    flags(1'b0, 1'b1);
    rdchk(S2, 32'h80);
    rdchk(S2 + 12'h4, 32'h01);
    rdchk(EV, 32'h6);
    rdchk(EV, 32'h0);
    flags(1'b0, 1'b0);
    apb(1'b1, S2, 32'h7f);
    rdchk(S2, 32'h80);
    apb(1'b1, S2, 32'h80);
    rdchk(S2, 32'h00);
    flags(1'b0, 1'b0);
    apb(1'b1, S2 + 12'h4, 32'hff);
    flags(1'b1, 1'b0);
    // masked event still latches the status bit
    apb(1'b1, MK, 32'h0);
    pulse(7'h40, '0);
    flags(1'b0, 1'b0);
    rdchk(EV, 32'h1);
    apb(1'b1, S1, 32'h01);
    flags(1'b1, 1'b0);
    // clock enable low: a pulse that rises and falls while frozen is never seen
    @(posedge pclk);
    ce <= 1'b0;
    pulse(7'h20, '0);
    @(posedge pclk);
    ce <= 1'b1;
    flags(1'b1, 1'b0);
    $display("test latch done");
    apb(1'b0, 12'h0c0, 32'h0);
    chk1("pslverr", 1'b1, err);
    chk32("unmapped read", 32'h0, rd);
    $display("test unmapped done");
    complete_run();
  end
endmodule : tb_dual_channel_irq_status
